// ---- common/esrm_pkg.sv ----
// Package: shared constants, register map and carriers of the emulator stop/reset/mapping block
package esrm_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ESRM_CTRL_OFS   = 12'h000;
  localparam logic [11:0] ESRM_CMD_OFS    = 12'h004;
  localparam logic [11:0] ESRM_STAT_OFS   = 12'h008;
  localparam logic [11:0] ESRM_MAPIDX_OFS = 12'h00C;
  localparam logic [11:0] ESRM_MAPDAT_OFS = 12'h010;
  localparam logic [11:0] ESRM_MAP_HI     = 12'hFFC;

  // CTRL fields
  localparam int ESRM_CTRL_KEEPI  = 0;
  localparam int ESRM_CTRL_RSTEN  = 1;
  localparam int ESRM_CTRL_SYNC   = 2;
  localparam int ESRM_CTRL_WPROT  = 3;
  localparam logic [31:0] ESRM_CTRL_RST = 32'h0000_0000;

  // CMD codes (write to CMD)
  localparam logic [1:0] ESRM_CMD_RUN   = 2'h1;
  localparam logic [1:0] ESRM_CMD_STOP  = 2'h2;
  localparam logic [1:0] ESRM_CMD_STEP  = 2'h3;
  localparam int         ESRM_CMD_SRCB  = 2;

  // STAT fields
  localparam int ESRM_ST_STOPPED = 0;
  localparam int ESRM_ST_SAVEDI  = 1;
  localparam int ESRM_ST_CPURST  = 2;
  localparam int ESRM_ST_WPWARN  = 3;
  localparam int ESRM_ST_SRCSTEP = 4;

  // ****************************************************************
  // Memory mapping: 16-bit space, 2-byte granules
  // ****************************************************************
  localparam int ESRM_AW      = 16;
  localparam int ESRM_GRAN_W  = 15;
  localparam int ESRM_GRANULE = 1 << ESRM_GRAN_W;

  typedef enum logic [1:0] {
    ESRM_MAP_TARGET = 2'b00,
    ESRM_MAP_EROM   = 2'b01,
    ESRM_MAP_ERAM   = 2'b10
  } esrm_map_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ESRM_CLK_MHZ      = 125;
  localparam int ESRM_POST_RST_MS  = 300;
  localparam int ESRM_POST_RST_CYC = ESRM_POST_RST_MS * ESRM_CLK_MHZ * 1000;

  // CPU memory access from the pod
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [ESRM_AW-1:0]   addr;
  } esrm_cpu_acc_t;

  // Per-access decision toward the memory system
  typedef struct packed {
    esrm_map_t            kind;
    logic                 wr_en;
  } esrm_mem_sel_t;

endpackage : esrm_pkg

// ---- rtl/esrm_ctrl.sv ----
// Module: emulator stop/step interrupt-mask handling, target reset sensing, memory mapping
//
// Functional notes
// (R1) Keep-interrupts option set: never touch CPU mask flag on stop or step.
// (R2) Option clear: save mask flag on stop entry, then set it.
// (R3) On resume, restore saved mask flag before letting execution continue.
// (R4) While stopped CPU is in background state; interrupts stay pending.
// (R5) Instruction step: detect mask changers; patch stacked copy on software interrupt.
// (R6) Source step runs to hidden breakpoints; no mask detection or correction.
// (R7) Stop persists over step and step-over; only run ends it (an emulator CPU reset also ends it here).
// (R8) Reset sensing on: target reset line resets CPU, even while running.
// (R9) Target reset resets CPU at once; hold reset a further delay after release.
// (R10) Sync start plus sensing: release CPU on watchdog reset rising edge.
// (R11) Target watchdog pulses while CPU held; application refreshes it after start.
// (R12) Each region is target, emulator read-only, or emulator read-write memory.
// (R13) Mapping type configurable per 2-byte granule over the address space.
// (R14) Protected read-only region write is blocked and raises warning.
// (R15) Saved mask in dedicated register; emulator reset of CPU clears it.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module esrm_ctrl
  import esrm_pkg::*;
#(
  parameter int POST_RST_CYC = ESRM_POST_RST_CYC
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          cpu_mask_flag,
  input  wire logic          cpu_mask_change,
  input  wire logic          cpu_swi_exec,
  output logic               cpu_bg_req,
  output logic               cpu_mask_wr,
  output logic               cpu_mask_val,
  output logic               stack_patch,
  output logic               stack_patch_val,
  output logic               src_step_run,
  input  wire logic          tgt_reset_n,
  output logic               cpu_reset_n,
  input  wire esrm_cpu_acc_t cpu_acc,
  output esrm_mem_sel_t      mem_sel,
  output logic               wp_warn
);

  // ****************************************************************
  // APB slave: zero wait states, unmapped reads zero with error
  // ****************************************************************
  logic        acc;
  logic        wr;
  logic [31:0] ctrl_q;
  logic [14:0] mapidx_q;
  logic [1:0]  map_mem [ESRM_GRANULE];
  logic        cmd_run;
  logic        cmd_stop;
  logic        cmd_step;
  logic        mapped;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite & clk_en;
  assign pready  = 1'b1;
  assign mapped  = (paddr <= ESRM_MAPDAT_OFS) && (paddr[1:0] == 2'b00);
  assign pslverr = acc & ~mapped;
  assign cmd_run  = wr && paddr == ESRM_CMD_OFS && pwdata[1:0] == ESRM_CMD_RUN;
  assign cmd_stop = wr && paddr == ESRM_CMD_OFS && pwdata[1:0] == ESRM_CMD_STOP;
  assign cmd_step = wr && paddr == ESRM_CMD_OFS && pwdata[1:0] == ESRM_CMD_STEP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= ESRM_CTRL_RST;
      mapidx_q <= '0;
    end else if (wr && paddr == ESRM_CTRL_OFS) begin
      ctrl_q   <= pwdata & 32'h0000_000F;
    end else if (wr && paddr == ESRM_MAPIDX_OFS) begin
      mapidx_q <= pwdata[14:0];
    end
  end

  // Map table has no reset: it is large and software loads it before use
  // (R12) three region kinds
  // (R13) one entry per 2-byte granule
  always_ff @(posedge pclk) begin
    if (wr && paddr == ESRM_MAPDAT_OFS) begin
      map_mem[mapidx_q] <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // Stop / step state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ESRM_RUNNING = 2'b00,
    ESRM_STOPPED = 2'b01,
    ESRM_ISTEP   = 2'b10,
    ESRM_SSTEP   = 2'b11
  } esrm_state_t;

  esrm_state_t state_q;
  logic        saved_i_q;
  logic        masked_q;
  logic        cpu_rst_q;
  logic        src_bp_hit;
  logic        wp_q;

  assign src_bp_hit = wr && paddr == ESRM_CMD_OFS && pwdata[1:0] == ESRM_CMD_STOP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ESRM_RUNNING;
    end else if (clk_en) begin
      if (cpu_rst_q) begin
        state_q <= ESRM_RUNNING;
      end else begin
        unique case (state_q)
          ESRM_RUNNING: if (cmd_stop) state_q <= ESRM_STOPPED;
          // (R7) only run or an emulator CPU reset leaves stop
          ESRM_STOPPED: begin
            if (cmd_run) begin
              state_q <= ESRM_RUNNING;
            end else if (cmd_step) begin
              state_q <= pwdata[ESRM_CMD_SRCB] ? ESRM_SSTEP : ESRM_ISTEP;
            end
          end
          // Step completes back into stop, not into running
          ESRM_ISTEP:   state_q <= ESRM_STOPPED;
          ESRM_SSTEP: begin
            if (cmd_run) begin
              state_q <= ESRM_RUNNING;
            end else if (src_bp_hit) begin
              state_q <= ESRM_STOPPED;
            end
          end
        endcase
      end
    end
  end

  // (R4) background state whenever stopped
  assign cpu_bg_req   = (state_q == ESRM_STOPPED);
  // (R6) source step is a plain run to hidden breakpoints
  assign src_step_run = (state_q == ESRM_SSTEP);

  // Saved mask register and masking flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_i_q <= 1'b0;
      masked_q  <= 1'b0;
    end else if (clk_en) begin
      if (cpu_rst_q) begin
        // (R15) cleared on emulator CPU reset
        saved_i_q <= 1'b0;
        masked_q  <= 1'b0;
      end else if (state_q == ESRM_RUNNING && cmd_stop && !ctrl_q[ESRM_CTRL_KEEPI]) begin
        // (R2) save then mask
        saved_i_q <= cpu_mask_flag;
        masked_q  <= 1'b1;
      end else if (state_q == ESRM_ISTEP && masked_q && cpu_mask_change && !cpu_swi_exec) begin
        // (R5) stepped instruction changed the mask: track it
        saved_i_q <= cpu_mask_flag;
      end else if (cmd_run && state_q != ESRM_RUNNING) begin
        masked_q  <= 1'b0;
      end
    end
  end

  // Mask writes toward the CPU, combinational with the command
  always_comb begin
    cpu_mask_wr  = 1'b0;
    cpu_mask_val = 1'b0;
    // (R1) no mask write when keep option set
    if (!ctrl_q[ESRM_CTRL_KEEPI]) begin
      if (state_q == ESRM_RUNNING && cmd_stop) begin
        cpu_mask_wr  = 1'b1;
        cpu_mask_val = 1'b1;
      end else if (cmd_run && masked_q && state_q != ESRM_RUNNING) begin
        // (R3) restore before run is released
        cpu_mask_wr  = 1'b1;
        cpu_mask_val = saved_i_q;
      end
    end
  end

  // (R5) patch stacked condition code copy on software interrupt step
  assign stack_patch     = (state_q == ESRM_ISTEP) && masked_q && cpu_swi_exec;
  assign stack_patch_val = saved_i_q;

  // ****************************************************************
  // Target reset sensing
  // ****************************************************************
  logic        tr_s1_q;
  logic        tr_s2_q;
  logic        tr_s3_q;
  logic [31:0] hold_q;
  logic        hold_act;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_s1_q <= 1'b1;
      tr_s2_q <= 1'b1;
      tr_s3_q <= 1'b1;
    end else if (clk_en) begin
      tr_s1_q <= tgt_reset_n;
      tr_s2_q <= tr_s1_q;
      tr_s3_q <= tr_s2_q;
    end
  end

  assign hold_act = (hold_q != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q    <= '0;
      cpu_rst_q <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_q[ESRM_CTRL_RSTEN] && !tr_s2_q) begin
        // (R8) (R9) immediate reset; sync mode loads hold once, else pulses never end it
        cpu_rst_q <= 1'b1;
        if (!(ctrl_q[ESRM_CTRL_SYNC] && cpu_rst_q)) hold_q <= POST_RST_CYC;
      end else if (cpu_rst_q) begin
        if (ctrl_q[ESRM_CTRL_SYNC] && ctrl_q[ESRM_CTRL_RSTEN]) begin
          // (R10) release on watchdog rising edge; (R11) pulses expected
          if (tr_s2_q && !tr_s3_q && !hold_act) cpu_rst_q <= 1'b0;
        end else if (!hold_act) begin
          cpu_rst_q <= 1'b0;
        end
        if (hold_act) hold_q <= hold_q - 32'd1;
      end
    end
  end

  assign cpu_reset_n = ~cpu_rst_q;

  // ****************************************************************
  // Mapping decision and write protection
  // ****************************************************************
  esrm_map_t kind;
  logic      blk;

  assign kind = esrm_map_t'(map_mem[cpu_acc.addr[ESRM_AW-1:1]]);
  // (R14) only emulator read-only memory is protected
  assign blk  = ctrl_q[ESRM_CTRL_WPROT] && kind == ESRM_MAP_EROM;

  always_comb begin
    mem_sel.kind  = kind;
    mem_sel.wr_en = cpu_acc.valid & cpu_acc.write & ~blk;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
    end else if (clk_en) begin
      // (R14) sticky warning; new hit wins over clear
      if (cpu_acc.valid && cpu_acc.write && blk) begin
        wp_q <= 1'b1;
      end else if (wr && paddr == ESRM_STAT_OFS && pwdata[ESRM_ST_WPWARN]) begin
        wp_q <= 1'b0;
      end
    end
  end

  assign wp_warn = wp_q;

  always_comb begin
    prdata = '0;
    if (acc && !pwrite) begin
      unique case (paddr)
        ESRM_CTRL_OFS:   prdata = ctrl_q;
        ESRM_STAT_OFS: begin
          prdata[ESRM_ST_STOPPED] = (state_q != ESRM_RUNNING);
          prdata[ESRM_ST_SAVEDI]  = saved_i_q;
          prdata[ESRM_ST_CPURST]  = cpu_rst_q;
          prdata[ESRM_ST_WPWARN]  = wp_q;
          prdata[ESRM_ST_SRCSTEP] = (state_q == ESRM_SSTEP);
        end
        ESRM_MAPIDX_OFS: prdata = {17'h0, mapidx_q};
        ESRM_MAPDAT_OFS: prdata = {30'h0, map_mem[mapidx_q]};
        default:         prdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_keep_no_wr;
    @(posedge pclk) disable iff (!presetn) ctrl_q[ESRM_CTRL_KEEPI] |-> !cpu_mask_wr;
  endproperty
  a_keep_no_wr: assert property (p_keep_no_wr) else $error("mask written with keep set"); // (R1)

  property p_save;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_q == ESRM_RUNNING && cmd_stop && !ctrl_q[ESRM_CTRL_KEEPI] && !cpu_rst_q)
      |=> (saved_i_q == $past(cpu_mask_flag)) && masked_q;
  endproperty
  a_save: assert property (p_save) else $error("mask not saved on stop"); // (R2)

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
      (cpu_mask_wr && state_q != ESRM_RUNNING) |-> cpu_mask_val == saved_i_q;
  endproperty
  a_restore: assert property (p_restore) else $error("wrong restore value"); // (R3)

  property p_patch;
    @(posedge pclk) disable iff (!presetn)
      stack_patch |-> stack_patch_val == saved_i_q && state_q == ESRM_ISTEP;
  endproperty
  a_patch: assert property (p_patch) else $error("bad stack patch"); // (R5)

  property p_src_nopatch;
    @(posedge pclk) disable iff (!presetn) src_step_run |-> !stack_patch;
  endproperty
  a_src_nopatch: assert property (p_src_nopatch) else $error("patch in source step"); // (R6)

  property p_istep_back;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_q == ESRM_ISTEP && !cpu_rst_q) |=> state_q == ESRM_STOPPED;
  endproperty
  a_istep_back: assert property (p_istep_back) else $error("step left stop"); // (R7)

  sequence s_tgt_low;
    clk_en && ctrl_q[ESRM_CTRL_RSTEN] && !tr_s2_q;
  endsequence
  property p_tgt_rst;
    @(posedge pclk) disable iff (!presetn) s_tgt_low |=> !cpu_reset_n;
  endproperty
  a_tgt_rst: assert property (p_tgt_rst) else $error("target reset not applied"); // (R8)

  property p_hold;
    @(posedge pclk) disable iff (!presetn) hold_act |-> !cpu_reset_n;
  endproperty
  a_hold: assert property (p_hold) else $error("released during hold"); // (R9)

  property p_wp;
    @(posedge pclk) disable iff (!presetn)
      (cpu_acc.valid && cpu_acc.write && blk) |-> !mem_sel.wr_en ##1 (wp_warn || !$past(clk_en));
  endproperty
  a_wp: assert property (p_wp) else $error("protected write passed"); // (R14)

endmodule : esrm_ctrl

// ---- tb/esrm_cpu_model.sv ----
// Model of the pod CPU mask flag and of the target reset line with its watchdog
`timescale 1ns/1ps
module esrm_cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cpu_mask_wr,
  input  wire logic cpu_mask_val,
  input  wire logic cpu_reset_n,
  input  wire logic prog_wr,
  input  wire logic prog_val,
  input  wire logic tgt_hold,
  input  wire logic wd_on,
  output logic      cpu_mask_flag,
  output logic      tgt_reset_n
);
  logic [4:0] wd_q;
  // Emulator writes win over the user program
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cpu_mask_flag <= 1'b0;
    else if (cpu_mask_wr) cpu_mask_flag <= cpu_mask_val;
    else if (prog_wr) cpu_mask_flag <= prog_val;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_q <= 5'h00;
    else if (wd_on && !cpu_reset_n) wd_q <= (wd_q == 5'h1D) ? 5'h00 : wd_q + 5'h01;
    else wd_q <= 5'h00;
  end
  assign tgt_reset_n = !(tgt_hold || (wd_on && !cpu_reset_n && wd_q < 5'h0A));
endmodule : esrm_cpu_model

// ---- tb/tb_top.sv ----
// Self-checking bench: stop and step mask handling, target reset, memory mapping
`timescale 1ns/1ps
module tb_top;
  import esrm_pkg::*;
  // Short hold keeps the run brief; both reset release-delay checks use it
  localparam int          POST   = 50;
  localparam logic [31:0] C_RUN  = {30'h0, ESRM_CMD_RUN};
  localparam logic [31:0] C_STOP = {30'h0, ESRM_CMD_STOP};
  localparam logic [31:0] C_STEP = {30'h0, ESRM_CMD_STEP};
  logic          pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          software_interrupt_instruction, bg_req, mwr, mval, spatch, spval, srun, tgt_n, crst_n, wp_warn;
  logic          mflag, prog_wr, prog_val, hold, wd_on, tgt_prev, mchg;
  esrm_cpu_acc_t acc;
  esrm_mem_sel_t sel;
  int            errors, total_checks, n, age;

  esrm_ctrl #(.POST_RST_CYC(POST)) i_esrm_ctrl (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_mask_flag(mflag), .cpu_mask_change(mchg), .cpu_swi_exec(software_interrupt_instruction),
    .cpu_bg_req(bg_req), .cpu_mask_wr(mwr), .cpu_mask_val(mval), .stack_patch(spatch),
    .stack_patch_val(spval), .src_step_run(srun), .tgt_reset_n(tgt_n),
    .cpu_reset_n(crst_n), .cpu_acc(acc), .mem_sel(sel), .wp_warn(wp_warn));
  esrm_cpu_model i_esrm_cpu_model (
    .pclk(pclk), .presetn(presetn), .cpu_mask_wr(mwr), .cpu_mask_val(mval),
    .cpu_reset_n(crst_n), .prog_wr(prog_wr), .prog_val(prog_val), .tgt_hold(hold),
    .wd_on(wd_on), .cpu_mask_flag(mflag), .tgt_reset_n(tgt_n));

  always #4 pclk = ~pclk;
  // Cycles since the target line last rose
  always @(posedge pclk) begin
    tgt_prev <= tgt_n;
    age      <= (tgt_n && !tgt_prev) ? 0 : age + 1;
  end

  function automatic logic stop_mask(input logic keep, input logic orig);
    return keep ? orig : 1'b1;
  endfunction : stop_mask
  function automatic logic wr_ok(input logic [1:0] kind, input logic wp);
    return !(wp && kind == ESRM_MAP_EROM);
  endfunction : wr_ok
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkw
  task automatic chk(input logic got, input logic exp);
    chkw({31'h0, got}, {31'h0, exp});
  endtask : chk
  // Setup at the next edge; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdr
  task automatic setm(input logic v);
    prog_wr  <= 1'b1;
    prog_val <= v;
    @(posedge pclk);
    prog_wr <= 1'b0;
  endtask : setm
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin : main
    logic        keep, orig;
    logic [14:0] base;
    {pclk, presetn, psel, penable, pwrite, software_interrupt_instruction, prog_wr, prog_val, hold, wd_on, mchg} = '0;
    {clk_en, tgt_prev, paddr, pwdata, acc, errors, total_checks, age} = '0;
    clk_en   = 1'b1;
    tgt_prev = 1'b1;
    void'($urandom(32'hAE8F));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdr(ESRM_CTRL_OFS);
    chkw(rd, ESRM_CTRL_RST);
    rdr(12'h020);
    chk(err, 1'b1);
    chkw(rd, 32'h0000_0000);
    // Frozen block must ignore the write
    clk_en <= 1'b0;
    wr(ESRM_CTRL_OFS, 32'h0000_000F);
    clk_en <= 1'b1;
    rdr(ESRM_CTRL_OFS);
    chkw(rd, ESRM_CTRL_RST);
    repeat (6) begin
      keep = 1'($urandom);
      orig = 1'($urandom);
      setm(orig);
      wr(ESRM_CTRL_OFS, {31'h0, keep});
      wr(ESRM_CMD_OFS, C_STOP);
      rdr(ESRM_STAT_OFS);
      chk(bg_req, 1'b1);
      chk(mflag, stop_mask(keep, orig));
      if (!keep) chk(rd[ESRM_ST_SAVEDI], orig);
      wr(ESRM_CMD_OFS, C_RUN);
      #1 chk(mflag, orig);
      rdr(ESRM_STAT_OFS);
      chk(rd[ESRM_ST_STOPPED], 1'b0);
    end
    setm(1'b0);
    wr(ESRM_CTRL_OFS, 32'h0000_0000);
    wr(ESRM_CMD_OFS, C_STOP);
    wr(ESRM_CMD_OFS, C_STEP);
    software_interrupt_instruction <= 1'b1;
    #1 chk(spatch, 1'b1);
    chk(spval, 1'b0);
    @(posedge pclk);
    software_interrupt_instruction <= 1'b0;
    rdr(ESRM_STAT_OFS);
    chk(rd[ESRM_ST_STOPPED], 1'b1);
    wr(ESRM_CMD_OFS, C_STEP | 32'h0000_0004);
    software_interrupt_instruction <= 1'b1;
    #1 chk(srun, 1'b1);
    chk(spatch, 1'b0);
    @(posedge pclk);
    software_interrupt_instruction <= 1'b0;
    wr(ESRM_CMD_OFS, C_STOP);
    #1 chk(srun, 1'b0);
    wr(ESRM_CMD_OFS, C_RUN);
    // Stepped mask changer must become the value restored on run
    setm(1'b1);
    wr(ESRM_CMD_OFS, C_STOP);
    setm(1'b0);
    wr(ESRM_CMD_OFS, C_STEP);
    mchg <= 1'b1;
    @(posedge pclk);
    mchg <= 1'b0;
    rdr(ESRM_STAT_OFS);
    chk(rd[ESRM_ST_SAVEDI], 1'b0);
    wr(ESRM_CMD_OFS, C_RUN);
    #1 chk(mflag, 1'b0);
    for (int b = 0; b < 3; b++) begin
      base = 15'($urandom);
      wr(ESRM_CTRL_OFS, {28'h0, b[0], 3'h0});
      for (int k = 0; k < 3; k++) begin
        wr(ESRM_MAPIDX_OFS, {17'h0, base + 15'(k)});
        wr(ESRM_MAPDAT_OFS, {30'h0, 2'(k)});
      end
      for (int k = 0; k < 3; k++) begin
        acc <= {1'b1, 1'b1, base + 15'(k), 1'($urandom)};
        #1 chkw({30'h0, sel.kind}, {30'h0, 2'(k)});
        chk(sel.wr_en, wr_ok(2'(k), b[0]));
        @(posedge pclk);
        acc <= '0;
        #1 chk(wp_warn, !wr_ok(2'(k), b[0]));
        wr(ESRM_STAT_OFS, 32'h0000_0008);
      end
    end
    setm(1'b1);
    wr(ESRM_CTRL_OFS, 32'h0000_0000);
    wr(ESRM_CMD_OFS, C_STOP);
    hold <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(crst_n, 1'b1);
    wr(ESRM_CTRL_OFS, 32'h0000_0002);
    repeat (5) @(posedge pclk);
    chk(crst_n, 1'b0);
    rdr(ESRM_STAT_OFS);
    chk(rd[ESRM_ST_SAVEDI], 1'b0);
    chk(rd[ESRM_ST_CPURST], 1'b1);
    hold <= 1'b0;
    n = 0;
    while (crst_n !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= POST && n <= POST + 8, 1'b1);
    wr(ESRM_CTRL_OFS, 32'h0000_0006);
    hold  <= 1'b1;
    wd_on <= 1'b1;
    repeat (6) @(posedge pclk);
    hold <= 1'b0;
    n = 0;
    while (crst_n !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= POST, 1'b1);
    chk(age <= 5, 1'b1);
    wd_on <= 1'b0;
    wr(ESRM_CMD_OFS, C_RUN);
    report_and_stop();
  end
endmodule : tb_top
